// *** sprc_map.vh ***
// register map, field positions and constants for the sleep/power/reset block
`ifndef SPRC_MAP_VH
`define SPRC_MAP_VH

// register word indices, matched against byte address bits 9:2 (byte offset is four times the index)
`define SPRC_IDX_MCU_CONTROL 8'h55
`define SPRC_IDX_CLOCK_GATE 8'h64
`define SPRC_IDX_SLEEP_CONTROL 8'h53
`define SPRC_IDX_STATUS 8'h70
`define SPRC_ADDR_W 10

// sleep_control fields
`define SPRC_SLP_ARM 0
`define SPRC_SLP_MODE_LO 1
`define SPRC_SLP_MODE_HI 3
`define SPRC_SLP_MASK 8'h0F

// mcu_control fields
`define SPRC_MCU_BOSO 6
`define SPRC_MCU_UNLOCK 5
`define SPRC_MCU_MASK 8'h33

// peripheral_clock_gate fields
`define SPRC_CG_TWI 7
`define SPRC_CG_TMR2 6
`define SPRC_CG_TMR0 5
`define SPRC_CG_TMR1 3
`define SPRC_CG_SPI 2
`define SPRC_CG_USART 1
`define SPRC_CG_CONV 0
`define SPRC_CG_MASK 8'hEF

// reset values
`define SPRC_RST_BYTE 8'h00

// sleep mode codes
`define SPRC_MODE_IDLE 3'h0
`define SPRC_MODE_NOISE 3'h1
`define SPRC_MODE_PDOWN 3'h2
`define SPRC_MODE_PSAVE 3'h3
`define SPRC_MODE_RSV4 3'h4
`define SPRC_MODE_RSV5 3'h5
`define SPRC_MODE_STBY 3'h6
`define SPRC_MODE_XSTBY 3'h7

// timing counts, in system clock cycles
`define SPRC_UNLOCK_WIN 3'h4
`define SPRC_BOSO_ACTIVE 2'h3
`define SPRC_BOSO_CLEAR 2'h3
`define SPRC_STBY_WAKE 3'h6

// ahb constants
`define SPRC_HTRANS_NONSEQ 2'h2
`define SPRC_HSIZE_WORD 3'h2

`endif

// *** sprc_top.v ***
// sleep mode, brown-out sleep-off, clock gating, reset combine and reference
//
// Function
// - decode three-bit sleep code; 100 and 101 reserved, no sleep.
// - sleep instruction enters sleep only while sleep_arm is one.
// - brownout_sleep_off set needs unlock write, then plain write within four.
// - brownout_sleep_off becomes effective three cycles after being set.
// - detector off in sleep only if sleep taken while sleep-off active.
// - brownout_sleep_off clears itself three cycles after being set.
// - clock-gate bit one stops that peripheral clock; bit 4 reads zero.
// - timer2 gate acts only when timer2 async select is zero.
// - ungated timer resumes from the exact state it held.
// - gated converter blocks comparator use of converter input mux.
// - reset restores all registers and starts at the reset vector.
// - port pins reset at once, without a clock, on power-on, pin or brown-out; watchdog through its clocked pulse.
// - delay counter stretches internal reset after all sources release.
// - internal reset combines power-on, pin, watchdog and brown-out.
// - pin reset ignored when disable fuse set; release starts delay.
// - brown-out asserts at once; delay starts when supply restored.
// - watchdog reset is a one-cycle pulse; delay starts at its end.
// - reference on if detector enabled, comparator route or converter on.
// - wake from standby or extended standby takes six cycles.
// - gated peripheral frozen; its registers neither written nor read.
`timescale 1ns/1ps
`include "sprc_map.vh"

module sprc_top #(
    parameter DELAY_W = 16
) (
    input wire i_clock,
    input wire i_rst_n,
    // ahb-lite slave
    input wire i_hsel,
    input wire [31:0] i_haddr,
    input wire [1:0] i_htrans,
    input wire i_hwrite,
    input wire [2:0] i_hsize,
    input wire [31:0] i_hwdata,
    input wire i_hready,
    output wire o_hreadyout,
    output wire o_hresp,
    output reg [31:0] o_hrdata,
    // core sleep handshake
    input wire i_sleep_instr,
    input wire i_wake,
    output reg o_sleeping,
    output reg [2:0] o_sleep_mode_code,
    output reg o_wake_done,
    output reg o_detector_sleep_off,
    // reset sources (asynchronous, from analog or pins)
    input wire i_por_n,
    input wire i_ext_reset_n,
    input wire i_wdt_expire,
    input wire i_brownout_low,
    input wire i_brownout_enable_fuse,
    input wire i_external_reset_disable_fuse,
    input wire [DELAY_W-1:0] i_reset_delay_cycles,
    output wire o_port_reset,
    output reg o_internal_reset,
    output reg o_wdt_reset_pulse,
    // peripheral clocks and reference
    input wire i_timer2_async_select,
    input wire i_comparator_bandgap_route,
    input wire i_converter_enable,
    output wire [7:0] o_periph_clock_en,
    output wire o_comparator_mux_allow,
    output wire o_reference_enable
);

// -----------------------------------------------------------------
// ahb-lite slave: zero wait states, always okay
// -----------------------------------------------------------------
reg wr_pend;
reg rd_pend;
reg [7:0] ap_addr;
wire ap_take = i_hsel & i_hready & (i_htrans == `SPRC_HTRANS_NONSEQ);

assign o_hreadyout = 1'b1;
assign o_hresp = 1'b0;

// latch the address phase; data phase follows one cycle later
always @(posedge i_clock) begin
    if (!i_rst_n) begin
        wr_pend <= 1'b0;
        rd_pend <= 1'b0;
        ap_addr <= `SPRC_RST_BYTE;
    end else begin
        wr_pend <= ap_take & i_hwrite;
        rd_pend <= ap_take & ~i_hwrite;
        ap_addr <= i_haddr[`SPRC_ADDR_W-1:2];
    end
end

wire wr_slp = wr_pend & (ap_addr == `SPRC_IDX_SLEEP_CONTROL);
wire wr_mcu = wr_pend & (ap_addr == `SPRC_IDX_MCU_CONTROL);
wire wr_cg = wr_pend & (ap_addr == `SPRC_IDX_CLOCK_GATE);
wire [7:0] wbyte = i_hwdata[7:0];

// -----------------------------------------------------------------
// registers
// -----------------------------------------------------------------
reg [7:0] sleep_control;
reg [7:0] mcu_misc;
reg [7:0] peripheral_clock_gate;
reg brownout_sleep_off;
reg [2:0] unlock_cnt;
reg [1:0] boso_age;

// write storage; reserved bits stay zero
always @(posedge i_clock) begin
    if (!i_rst_n) begin
        sleep_control <= `SPRC_RST_BYTE;
        mcu_misc <= `SPRC_RST_BYTE;
        peripheral_clock_gate <= `SPRC_RST_BYTE;
    end else begin
        if (wr_slp)
            sleep_control <= wbyte & `SPRC_SLP_MASK;
        if (wr_mcu)
            mcu_misc <= wbyte & `SPRC_MCU_MASK;
        if (wr_cg)
            peripheral_clock_gate <= wbyte & `SPRC_CG_MASK;
    end
end

wire unlock_wr = wr_mcu & wbyte[`SPRC_MCU_BOSO] & wbyte[`SPRC_MCU_UNLOCK];
wire set_wr = wr_mcu & wbyte[`SPRC_MCU_BOSO] & ~wbyte[`SPRC_MCU_UNLOCK];

// timed unlock: window of four cycles opens on the unlock write
always @(posedge i_clock) begin
    if (!i_rst_n) begin
        unlock_cnt <= 3'h0;
    end else if (unlock_wr) begin
        unlock_cnt <= `SPRC_UNLOCK_WIN;
    end else if (unlock_cnt != 3'h0) begin
        unlock_cnt <= unlock_cnt - 3'h1;
    end
end

// sleep-off bit: set only inside the window, self-clears after three
always @(posedge i_clock) begin
    if (!i_rst_n) begin
        brownout_sleep_off <= 1'b0;
        boso_age <= 2'h0;
    end else if (set_wr && unlock_cnt != 3'h0 && !brownout_sleep_off) begin
        brownout_sleep_off <= 1'b1;
        boso_age <= 2'h0;
    end else if (brownout_sleep_off) begin
        if (boso_age == `SPRC_BOSO_CLEAR - 2'h1)
            brownout_sleep_off <= 1'b0;
        boso_age <= boso_age + 2'h1;
    end
end

// a short delay line makes the bit effective three cycles after setting;
// since it also clears after three, the active window is the clear edge
reg [2:0] boso_dly;
always @(posedge i_clock) begin
    if (!i_rst_n)
        boso_dly <= 3'h0;
    else
        boso_dly <= {boso_dly[1:0], brownout_sleep_off & (boso_age == 2'h0)};
end
wire boso_active = boso_dly[`SPRC_BOSO_ACTIVE-1];

// read mux; unmapped offsets read zero
wire [7:0] mcu_rd = mcu_misc | {1'b0, brownout_sleep_off, 6'h00};
wire [7:0] status = {o_internal_reset, o_detector_sleep_off, o_sleeping,
                     boso_active, 1'b0, o_sleep_mode_code};
always @(posedge i_clock) begin
    if (!i_rst_n) begin
        o_hrdata <= 32'h0000_0000;
    end else if (ap_take & ~i_hwrite) begin
        case (i_haddr[`SPRC_ADDR_W-1:2])
            `SPRC_IDX_SLEEP_CONTROL: o_hrdata <= {24'h000000, sleep_control};
            `SPRC_IDX_MCU_CONTROL: o_hrdata <= {24'h000000, mcu_rd};
            `SPRC_IDX_CLOCK_GATE:
                o_hrdata <= {24'h000000, peripheral_clock_gate};
            `SPRC_IDX_STATUS: o_hrdata <= {24'h000000, status};
            default: o_hrdata <= 32'h0000_0000;
        endcase
    end
end

// -----------------------------------------------------------------
// sleep control
// -----------------------------------------------------------------
localparam ST_RUN = 2'h0;
localparam ST_SLEEP = 2'h1;
localparam ST_WAKE = 2'h2;

reg [1:0] state;
reg [2:0] wake_cnt;
wire [2:0] mode_sel = sleep_control[`SPRC_SLP_MODE_HI:`SPRC_SLP_MODE_LO];
wire mode_ok = (mode_sel != `SPRC_MODE_RSV4) &&
               (mode_sel != `SPRC_MODE_RSV5);
wire osc_runs = (o_sleep_mode_code == `SPRC_MODE_STBY) ||
                (o_sleep_mode_code == `SPRC_MODE_XSTBY);

// sleep entry, wake wait; other modes wake in one cycle here since the
// oscillator restart time lives outside this block
always @(posedge i_clock) begin
    if (!i_rst_n) begin
        state <= ST_RUN;
        wake_cnt <= 3'h0;
        o_sleeping <= 1'b0;
        o_sleep_mode_code <= `SPRC_MODE_IDLE;
        o_wake_done <= 1'b0;
        o_detector_sleep_off <= 1'b0;
    end else begin
        o_wake_done <= 1'b0;
        case (state)
            ST_RUN: begin
                if (i_sleep_instr && sleep_control[`SPRC_SLP_ARM] &&
                    mode_ok) begin
                    state <= ST_SLEEP;
                    o_sleeping <= 1'b1;
                    o_sleep_mode_code <= mode_sel;
                    o_detector_sleep_off <= boso_active;
                end
            end
            ST_SLEEP: begin
                if (i_wake) begin
                    state <= ST_WAKE;
                    wake_cnt <= osc_runs ? `SPRC_STBY_WAKE - 3'h1 : 3'h0;
                end
            end
            ST_WAKE: begin
                if (wake_cnt == 3'h0) begin
                    state <= ST_RUN;
                    o_sleeping <= 1'b0;
                    o_detector_sleep_off <= 1'b0;
                    o_wake_done <= 1'b1;
                end else begin
                    wake_cnt <= wake_cnt - 3'h1;
                end
            end
            default: state <= ST_RUN;
        endcase
    end
end

// -----------------------------------------------------------------
// clock gating and reference
// -----------------------------------------------------------------
// an enable only stalls the peripheral, so its state is kept
genvar g;
generate
    for (g = 0; g < 8; g = g + 1) begin : gen_cg
        if (g == `SPRC_CG_TMR2) begin : gen_t2
            assign o_periph_clock_en[g] = ~(peripheral_clock_gate[g] &
                                            ~i_timer2_async_select);
        end else begin : gen_plain
            assign o_periph_clock_en[g] = ~peripheral_clock_gate[g];
        end
    end
endgenerate

assign o_comparator_mux_allow = ~peripheral_clock_gate[`SPRC_CG_CONV];

// brown-out enable in sleep is dropped only when detector sleep-off holds
wire bod_on = i_brownout_enable_fuse & ~o_detector_sleep_off;
assign o_reference_enable = bod_on | i_comparator_bandgap_route |
                            i_converter_enable;

// -----------------------------------------------------------------
// reset combine and stretch
// -----------------------------------------------------------------
// asynchronous combine drives the port reset without a clock
wire ext_src = ~i_ext_reset_n & ~i_external_reset_disable_fuse;
wire bod_src = i_brownout_low & i_brownout_enable_fuse;
assign o_port_reset = ~i_por_n | ext_src | bod_src |
                      o_wdt_reset_pulse;

reg [1:0] src_sync;
reg [1:0] wdt_sync;
reg wdt_seen;
reg [DELAY_W-1:0] delay_cnt;

// two-stage synchronisers for asynchronous sources
always @(posedge i_clock) begin
    src_sync <= {src_sync[0], ~i_por_n | ext_src | bod_src};
    wdt_sync <= {wdt_sync[0], i_wdt_expire};
end

// watchdog expiry edge gives a one-cycle reset pulse
always @(posedge i_clock) begin
    if (!i_rst_n) begin
        wdt_seen <= 1'b0;
        o_wdt_reset_pulse <= 1'b0;
    end else begin
        wdt_seen <= wdt_sync[1];
        o_wdt_reset_pulse <= wdt_sync[1] & ~wdt_seen;
    end
end

// stretch: counter reloads while any source is active, counts after
always @(posedge i_clock) begin
    if (!i_rst_n) begin
        delay_cnt <= {DELAY_W{1'b0}};
        o_internal_reset <= 1'b1;
    end else if (src_sync[1] | o_wdt_reset_pulse) begin
        delay_cnt <= i_reset_delay_cycles;
        o_internal_reset <= 1'b1;
    end else if (delay_cnt != {DELAY_W{1'b0}}) begin
        delay_cnt <= delay_cnt - {{(DELAY_W-1){1'b0}}, 1'b1};
    end else begin
        o_internal_reset <= 1'b0;
    end
end

endmodule

// *** sprc_chk.sv ***
// concurrent checks on the sleep, power and reset block ports
`timescale 1ns/1ps
module sprc_chk (
    input wire i_clock,
    input wire i_rst_n,
    input wire i_sleep_instr,
    input wire i_wake,
    input wire o_sleeping,
    input wire [2:0] o_sleep_mode_code,
    input wire o_wake_done,
    input wire o_detector_sleep_off,
    input wire i_por_n,
    input wire i_ext_reset_n,
    input wire i_brownout_low,
    input wire i_brownout_enable_fuse,
    input wire i_external_reset_disable_fuse,
    input wire o_port_reset,
    input wire o_internal_reset,
    input wire o_wdt_reset_pulse,
    input wire i_timer2_async_select,
    input wire i_comparator_bandgap_route,
    input wire i_converter_enable,
    input wire [7:0] o_periph_clock_en,
    input wire o_comparator_mux_allow,
    input wire o_reference_enable
);
    // ------------------------------------------------------------
    // properties, all in the system clock domain
    // ------------------------------------------------------------
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (!i_rst_n);
    a_port_por: assert property (!i_por_n |-> o_port_reset)
        else $error("power-on low but port reset idle");
    a_port_pin: assert property ((!i_ext_reset_n
        && !i_external_reset_disable_fuse) |-> o_port_reset)
        else $error("pin low but port reset idle");
    a_port_brown: assert property ((i_brownout_low
        && i_brownout_enable_fuse) |-> o_port_reset)
        else $error("brown-out but port reset idle");
    a_int_follow: assert property (o_port_reset
        |-> ##[0:3] o_internal_reset)
        else $error("internal reset missed a source");
    // stretch: port reset must have been low one cycle and four cycles before the release
    a_reset_stretch: assert property ($fell(o_internal_reset)
        |-> !$past(o_port_reset) && !$past(o_port_reset, 4))
        else $error("internal reset released too early");
    a_wdt_width: assert property (o_wdt_reset_pulse
        |=> !o_wdt_reset_pulse && o_internal_reset)
        else $error("watchdog pulse not one cycle");
    a_ref_on: assert property (o_reference_enable
        == ((i_brownout_enable_fuse && !o_detector_sleep_off)
        || i_comparator_bandgap_route
        || i_converter_enable))
        else $error("reference enable wrong");
    a_mux_gated: assert property (!o_periph_clock_en[0]
        |-> !o_comparator_mux_allow)
        else $error("comparator mux usable while gated");
    a_tmr2_async: assert property (i_timer2_async_select
        |-> o_periph_clock_en[6])
        else $error("timer2 gated in async mode");
    a_sleep_entry: assert property ($rose(o_sleeping)
        |-> $past(i_sleep_instr) && o_sleep_mode_code[2:1] != 2'h2)
        else $error("bad sleep entry");
    a_stby_wake: assert property ((o_sleeping && i_wake
        && o_sleep_mode_code[2:1] == 2'h3) |-> ##[5:7] o_wake_done)
        else $error("standby wake not six cycles");
    a_off_asleep: assert property ($rose(o_detector_sleep_off)
        |-> o_sleeping)
        else $error("detector off outside sleep");
    c_det_off: cover property ($rose(o_detector_sleep_off));
    c_stretch: cover property ($fell(o_internal_reset));
    c_stby: cover property (o_wake_done && o_sleep_mode_code == 3'h6);
endmodule

bind sprc_top sprc_chk sprc_chk_inst (.*);

// *** sprc_core_model.sv ***
// core model: ahb-lite register master and sleep instruction source
`timescale 1ns/1ps
module sprc_core_model (
    input wire i_clock,
    input wire i_hready,
    input wire [31:0] i_hrdata,
    output reg o_hsel,
    output reg [31:0] o_haddr,
    output reg [1:0] o_htrans,
    output reg o_hwrite,
    output reg [2:0] o_hsize,
    output reg [31:0] o_hwdata,
    output reg o_sleep_instr
);
    // ------------------------------------------------------------
    // bus phases; every change lands just after a rising edge
    // ------------------------------------------------------------
    initial begin
        o_hsel = 1'b1;
        o_haddr = 32'h0;
        o_htrans = 2'h0;
        o_hwrite = 1'b0;
        o_hsize = 3'h2;
        o_hwdata = 32'h0;
        o_sleep_instr = 1'b0;
    end
    task rdy;
        begin
            @(posedge i_clock);
            while (!i_hready) @(posedge i_clock);
        end
    endtask
    // stale write data is inverted so it never looks valid
    task ph(input [31:0] a, input w);
        begin
            o_haddr <= a;
            o_hwrite <= w;
            o_htrans <= 2'h2;
            o_hwdata <= ~o_hwdata;
            rdy;
            o_htrans <= 2'h0;
        end
    endtask
    task wr0(input [31:0] a, input [31:0] d);
        begin
            ph(a, 1'b1);
            o_hwdata <= d;
            rdy;
        end
    endtask
    task wr(input [31:0] a, input [31:0] d);
        begin
            @(posedge i_clock);
            wr0(a, d);
        end
    endtask
    task rd(input [31:0] a, output [31:0] d);
        begin
            @(posedge i_clock);
            ph(a, 1'b0);
            rdy;
            d = i_hrdata;
        end
    endtask
    // unlock then plain write, two cycles apart; u=0 skips unlock
    task bo_seq(input u);
        begin
            wr(32'h154, u ? 32'h60 : 32'h40);
            wr0(32'h154, 32'h40);
        end
    endtask
    // one-cycle sleep instruction, issued after the caller has written sleep_control
    task nap;
        begin
            o_sleep_instr <= 1'b1;
            @(posedge i_clock);
            o_sleep_instr <= 1'b0;
        end
    endtask
endmodule

// *** sleep_power_reset_control_bench.sv ***
// self-checking bench for the sleep, power and reset block
`timescale 1ns/1ps
module sleep_power_reset_control_bench;
    // ------------------------------------------------------------
    // stimulus, instances and helpers
    // ------------------------------------------------------------
    localparam SLP = 32'h14C, MCU = 32'h154, CG = 32'h190;
    reg clk = 1'b0, rst_n = 1'b0, wake = 1'b0, por_n = 1'b1;
    reg ext_n = 1'b1, wdt = 1'b0, brown = 1'b0, bo_en = 1'b0;
    reg nopin = 1'b0, as2 = 1'b0, route = 1'b0, conv = 1'b0;
    wire hsel, hwrite, hrdy, hresp, si, slpg, wdone, doff;
    wire prst, irst, wpul, mux, vref;
    wire [1:0] htrans;
    wire [2:0] hsize, mode;
    wire [7:0] cken;
    wire [31:0] haddr, hwdata, hrdata;
    integer n_mismatch = 0, n_compared = 0, cyc = 0, m, k, h, u;
    reg [31:0] d;
    sprc_core_model cpu (.i_clock(clk), .i_hready(hrdy), .i_hrdata(hrdata),
        .o_hsel(hsel), .o_haddr(haddr), .o_htrans(htrans),
        .o_hwrite(hwrite), .o_hsize(hsize), .o_hwdata(hwdata),
        .o_sleep_instr(si));
    sprc_top sprc_top_inst (.i_clock(clk), .i_rst_n(rst_n), .i_hsel(hsel),
        .i_haddr(haddr), .i_htrans(htrans), .i_hwrite(hwrite),
        .i_hsize(hsize), .i_hwdata(hwdata), .i_hready(hrdy),
        .o_hreadyout(hrdy), .o_hresp(hresp), .o_hrdata(hrdata),
        .i_sleep_instr(si), .i_wake(wake), .o_sleeping(slpg),
        .o_sleep_mode_code(mode), .o_wake_done(wdone),
        .o_detector_sleep_off(doff), .i_por_n(por_n),
        .i_ext_reset_n(ext_n), .i_wdt_expire(wdt),
        .i_brownout_low(brown), .i_brownout_enable_fuse(bo_en),
        .i_external_reset_disable_fuse(nopin),
        .i_reset_delay_cycles(16'h0004), .o_port_reset(prst),
        .o_internal_reset(irst), .o_wdt_reset_pulse(wpul),
        .i_timer2_async_select(as2), .i_comparator_bandgap_route(route),
        .i_converter_enable(conv), .o_periph_clock_en(cken),
        .o_comparator_mux_allow(mux), .o_reference_enable(vref));
    always #12.5 clk = ~clk;
    // hang guard, well above the expected few hundred cycles
    always @(posedge clk) begin
        cyc = cyc + 1;
        if (cyc == 30000) begin
            n_mismatch = n_mismatch + 1;
            stop_test;
        end
    end
    task stop_test;
        begin
            $display("compared %0d mismatched %0d", n_compared, n_mismatch);
            if (n_mismatch == 0 && n_compared > 0)
                $display("Regression OK");
            else
                $display("Regression broken");
            $finish;
        end
    endtask
    task chk(input [31:0] g, input [31:0] e);
        begin
            n_compared = n_compared + 1;
            if (g !== e) begin
                n_mismatch = n_mismatch + 1;
                $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
            end
        end
    endtask
    task wake_up;
        begin
            @(posedge clk) wake <= 1'b1;
            @(posedge clk) wake <= 1'b0;
            for (k = 0; k < 20 && wdone !== 1'b1; k = k + 1)
                @(posedge clk) #1;
        end
    endtask
    // waits for the stretch to start, then counts until it ends
    task rst_wait;
        begin
            for (k = 0; k < 6 && irst !== 1'b1; k = k + 1) @(posedge clk) #1;
            for (k = 0; k < 60 && irst !== 1'b0; k = k + 1) @(posedge clk) #1;
        end
    endtask
    task reg_rw(input [31:0] a, input [31:0] w, input [31:0] e);
        begin
            cpu.rd(a, d);
            chk(d, 32'h0);
            cpu.wr(a, w);
            cpu.rd(a, d);
            chk(d, e);
        end
    endtask
    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task t_regs;
        begin
            reg_rw(SLP, 32'hFF, 32'h0F);
            reg_rw(MCU, 32'h17, 32'h13);
            reg_rw(CG, 32'hFF, 32'hEF); // converter held off
            reg_rw(32'h3FC, 32'hFF, 32'h0);
            chk(cken & 8'hEF, 8'h00);
            chk(mux, 1'b0);
            @(posedge clk) as2 <= 1'b1;
            #1 chk(cken[6], 1'b1);
            cpu.wr(CG, 32'h0); // serial blocks idle, nothing to redo
            #1 chk(cken & 8'hEF, 8'hEF);
            cpu.wr(MCU, 32'h0);
        end
    endtask
    // every mode code, standby modes wake slower; unarmed sleep ignored
    task t_sleep;
        begin
            for (m = 0; m < 9; m = m + 1) begin
                cpu.wr(SLP, m < 8 ? (m * 2 + 1) : 32'h4);
                cpu.nap;
                #1 chk(slpg, m < 8 && m != 4 && m != 5);
                if (slpg === 1'b1) begin
                    chk(mode, m);
                    wake_up;
                    chk(k >= 4, m >= 6);
                end
            end
        end
    endtask
    // sleep at each offset after the sequence; only unlocked one hits
    task t_brownout_sleep_off;
        for (u = 1; u >= 0; u = u - 1) begin
            h = 0;
            for (m = 0; m < 6; m = m + 1) begin
                cpu.wr(SLP, 32'h5);
                cpu.bo_seq(u);
                repeat (m) @(posedge clk);
                cpu.nap;
                #1 h = h + (doff === 1'b1);
                if (slpg === 1'b1) wake_up;
            end
            chk(h, u);
            cpu.rd(MCU, d);
            chk(d & 32'h40, 32'h0);
        end
    endtask
    task t_resets;
        begin
            @(posedge clk) por_n <= 1'b0;
            #1 chk(prst, 1'b1);
            @(posedge clk) por_n <= 1'b1;
            rst_wait;
            chk(k >= 4 && k < 60, 1'b1);
            @(posedge clk) {nopin, ext_n} <= 2'h2;
            #1 chk(prst, 1'b0);
            @(posedge clk) nopin <= 1'b0;
            #1 chk(prst, 1'b1);
            @(posedge clk) {ext_n, brown, bo_en} <= 3'h6;
            #1 chk(prst, 1'b0);
            @(posedge clk) bo_en <= 1'b1;
            #1 chk(prst, 1'b1);
            @(posedge clk) brown <= 1'b0;
            rst_wait;
            chk(irst, 1'b0);
            chk(k >= 4, 1'b1);
            @(posedge clk) wdt <= 1'b1;
            @(posedge clk) wdt <= 1'b0;
            for (k = 0; k < 6 && wpul !== 1'b1; k = k + 1) @(posedge clk) #1;
            chk(wpul, 1'b1);
            rst_wait;
            chk(irst, 1'b0);
            chk(k >= 4, 1'b1);
        end
    endtask
    task t_ref;
        for (m = 0; m < 8; m = m + 1) begin
            @(posedge clk) {bo_en, route, conv} <= m[2:0];
            #1 chk(vref, m != 0); // output also checked by a_ref_on in the checker; it drives nothing
        end
    endtask
    initial begin
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        rst_wait;
        t_regs;
        t_sleep;
        t_brownout_sleep_off;
        t_ref;
        t_resets;
        stop_test;
    end
endmodule
